// ### pcs_consts.svh
// Purpose: Constants for the phase calibration and power sign registers
// Assumes: Register index times four gives the AHB byte address
// Notes:   Offsets, field positions, reset values and code limits
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define PCS_IDX_PHASE_A   16'he614
`define PCS_IDX_PHASE_B   16'he615
`define PCS_IDX_PHASE_C   16'he616
`define PCS_IDX_SIGN      16'he617
`define PCS_IDX_CTRL      16'he640
`define PCS_IDX_TERM_SEL  16'he641
`define PCS_IDX_QUANT_SEL 16'he642
`define PCS_IDX_IRQ_STAT  16'he643
`define PCS_IDX_IRQ_MASK  16'he644

// ----------------------------------------------------------------
// Fields and codes
// ----------------------------------------------------------------
`define PCS_CODE_W        10
`define PCS_CUR_MAX       10'h17f
`define PCS_ALIAS_MAX     10'h1ff
`define PCS_VOLT_LO       10'h200
`define PCS_VOLT_MAX      10'h23f
`define PCS_ALIAS_STEP    10'h080
`define PCS_ALIAS_BASE    10'h100
`define PCS_SIGN_W        9
`define PCS_BIT_SUM1      3
`define PCS_BIT_SUM2      7
`define PCS_BIT_SUM3      8
`define PCS_BIT_ACT_SEL   0
`define PCS_BIT_REACT_SEL 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PCS_RST_CODE      10'h000
`define PCS_RST_SIGN      9'h000
`define PCS_RST_CTRL      2'h0
`define PCS_RST_TERM      9'h1ff
`define PCS_RST_QUANT     9'h088

`endif

// ### pcs_pkg.sv
// Purpose: Types shared by the phase calibration register block
// Assumes: Nothing beyond the constants header
// Notes:   Quantity codes follow the pulse quantity select encoding
`default_nettype none

package pcs_pkg;

	typedef logic [9:0] pcs_code_t;

	typedef logic [8:0] pcs_sign_t;

	typedef enum logic [2:0] {
		PCS_Q_ACT,
		PCS_Q_REACT,
		PCS_Q_APP,
		PCS_Q_FACT,
		PCS_Q_FREACT
	} pcs_quant_e;

endpackage

`default_nettype wire

// ### pcs_regs.sv
// Purpose: Phase delay calibration and power polarity registers, AHB-Lite
// Assumes: One slave on the bus, single word transfers
// Notes:   Reads take one wait state, writes none
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "pcs_consts.svh"

module pcs_regs #(
	parameter int PW           = 24,
	parameter bit HAS_REACTIVE = 1'b1
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	input  wire logic                  power_update,
	input  wire logic [3*PW-1:0]       total_active,
	input  wire logic [3*PW-1:0]       total_reactive,
	input  wire logic [3*PW-1:0]       apparent,
	input  wire logic [3*PW-1:0]       fund_active,
	input  wire logic [3*PW-1:0]       fund_reactive,
	output logic [26:0]                delay_comp_value,
	output logic [2:0]                 delay_on_voltage,
	output pcs_pkg::pcs_sign_t         power_polarity_status,
	output logic                       irq
);
	import pcs_pkg::*;

	// ----------------------------------------------------------------
	// Bus address and data phase tracking
	// ----------------------------------------------------------------
	logic        take;
	logic        dp_write;
	logic        dp_read;
	logic        rd_ready;
	logic [15:0] dp_index;
	logic        dp_mapped;
	logic [15:0] next_index;
	logic        next_mapped;

	assign take = hsel & htrans[1] & hready;
	assign next_index = haddr[17:2];
	assign next_mapped = (haddr[31:18] == 14'h0000) &
	                     (haddr[1:0] == 2'b00);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dp_write  <= 1'b0;
			dp_index  <= 16'h0000;
			dp_mapped <= 1'b0;
		end else if (hready) begin
			dp_write  <= take & hwrite;
			dp_index  <= next_index;
			dp_mapped <= next_mapped;
		end
	end

	// ----------------------------------------------------------------
	// Read wait state
	// ----------------------------------------------------------------

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dp_read  <= 1'b0;
			rd_ready <= 1'b0;
		end else if (dp_read & rd_ready) begin
			dp_read  <= take & ~hwrite;
			rd_ready <= 1'b0;
		end else if (dp_read) begin
			rd_ready <= 1'b1;
		end else if (hready) begin
			dp_read  <= take & ~hwrite;
		end
	end

	// ----------------------------------------------------------------
	// Bus response
	// ----------------------------------------------------------------
	assign hreadyout = ~(dp_read & ~rd_ready);
	assign hresp     = 1'b0;

	// ----------------------------------------------------------------
	// Write strobe
	// ----------------------------------------------------------------
	logic wr_en;
	assign wr_en = dp_write & dp_mapped;

	function automatic logic hit(input logic [15:0] idx);
		hit = wr_en & (dp_index == idx);
	endfunction

	// ----------------------------------------------------------------
	// Phase calibration words
	// ----------------------------------------------------------------
	pcs_code_t cal_code [3];

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_cal
			logic [15:0] idx;
			assign idx = `PCS_IDX_PHASE_A + 16'(g);

			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					cal_code[g] <= `PCS_RST_CODE;
				end else if (hit(idx)) begin
					cal_code[g] <= hwdata[9:0];
				end
			end

			pcs_code_t eff;
			logic      on_volt;

			always_comb begin
				eff     = cal_code[g];
				on_volt = 1'b0;
				if (cal_code[g] <= `PCS_CUR_MAX) begin
					eff = cal_code[g];
				end else if (cal_code[g] <= `PCS_ALIAS_MAX) begin
					eff = cal_code[g] - `PCS_ALIAS_STEP;
				end else if (cal_code[g] <= `PCS_VOLT_MAX) begin
					eff     = cal_code[g] - `PCS_VOLT_LO;
					on_volt = 1'b1;
				end else begin
					eff = `PCS_ALIAS_BASE + {3'b000, cal_code[g][6:0]};
				end
			end

			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					delay_comp_value[g*9 +: 9] <= 9'h000;
					delay_on_voltage[g]        <= 1'b0;
				end else begin
					delay_comp_value[g*9 +: 9] <= eff[8:0];
					delay_on_voltage[g]        <= on_volt;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Source and datapath selection
	// ----------------------------------------------------------------
	logic [1:0] ctrl;
	logic [8:0] term_sel;
	logic [8:0] quant_sel;

	// ----------------------------------------------------------------
	// Control word
	// ----------------------------------------------------------------

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl <= `PCS_RST_CTRL;
		end else if (hit(`PCS_IDX_CTRL)) begin
			ctrl <= hwdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Datapath term select
	// ----------------------------------------------------------------

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			term_sel <= `PCS_RST_TERM;
		end else if (hit(`PCS_IDX_TERM_SEL)) begin
			term_sel <= hwdata[8:0];
		end
	end

	// ----------------------------------------------------------------
	// Datapath quantity select
	// ----------------------------------------------------------------

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			quant_sel <= `PCS_RST_QUANT;
		end else if (hit(`PCS_IDX_QUANT_SEL)) begin
			quant_sel <= hwdata[8:0];
		end
	end

	// ----------------------------------------------------------------
	// Per-phase quantity pick
	// ----------------------------------------------------------------
	function automatic logic [PW-1:0] pick(input logic [2:0] q,
	                                       input int         p);
		logic [PW-1:0] react;
		logic [PW-1:0] freact;
		react  = HAS_REACTIVE ? total_reactive[p*PW +: PW] : '0;
		freact = HAS_REACTIVE ? fund_reactive[p*PW +: PW] : '0;
		case (q)
			PCS_Q_REACT:  pick = react;
			PCS_Q_APP:    pick = apparent[p*PW +: PW];
			PCS_Q_FACT:   pick = fund_active[p*PW +: PW];
			PCS_Q_FREACT: pick = freact;
			default:      pick = total_active[p*PW +: PW];
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Polarity computation
	// ----------------------------------------------------------------
	pcs_sign_t next_sign;
	logic [2:0] sum_neg;

	generate
		for (g = 0; g < 3; g++) begin : g_sum
			logic signed [PW+1:0] acc;
			always_comb begin
				acc = '0;
				for (int p = 0; p < 3; p++) begin
					if (term_sel[g*3 + p]) begin
						acc = acc + (PW+2)'($signed(
						      pick(quant_sel[g*3 +: 3], p)));
					end
				end
			end
			assign sum_neg[g] = acc[PW+1];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Per-phase sign bits
	// ----------------------------------------------------------------
	generate
		for (g = 0; g < 3; g++) begin : g_phase
			logic [PW-1:0] act;
			logic [PW-1:0] rea;
			assign act = ctrl[`PCS_BIT_ACT_SEL] ?
			             fund_active[g*PW +: PW] :
			             total_active[g*PW +: PW];
			assign rea = ctrl[`PCS_BIT_REACT_SEL] ?
			             fund_reactive[g*PW +: PW] :
			             total_reactive[g*PW +: PW];
			assign next_sign[g] = act[PW-1];
			assign next_sign[4+g] = HAS_REACTIVE & rea[PW-1];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Datapath sum bits
	// ----------------------------------------------------------------
	assign next_sign[`PCS_BIT_SUM1] = sum_neg[0];
	assign next_sign[`PCS_BIT_SUM2] = sum_neg[1];
	assign next_sign[`PCS_BIT_SUM3] = sum_neg[2];

	// ----------------------------------------------------------------
	// Sign register
	// ----------------------------------------------------------------

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			power_polarity_status <= `PCS_RST_SIGN;
		end else if (power_update) begin
			power_polarity_status <= next_sign;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts on polarity change
	// ----------------------------------------------------------------
	pcs_sign_t irq_stat;
	pcs_sign_t irq_mask;
	pcs_sign_t flip;
	pcs_sign_t clr;

	assign flip = power_update ?
	              (next_sign ^ power_polarity_status) : 9'h000;
	assign clr  = hit(`PCS_IDX_IRQ_STAT) ? hwdata[8:0] : 9'h000;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_stat <= 9'h000;
		end else begin
			irq_stat <= (irq_stat & ~clr) | flip;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt mask
	// ----------------------------------------------------------------

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_mask <= 9'h000;
		end else if (hit(`PCS_IDX_IRQ_MASK)) begin
			irq_mask <= hwdata[8:0];
		end
	end

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (dp_mapped) begin
			case (dp_index)
				`PCS_IDX_PHASE_A:   rd_mux[9:0] = cal_code[0];
				`PCS_IDX_PHASE_B:   rd_mux[9:0] = cal_code[1];
				`PCS_IDX_PHASE_C:   rd_mux[9:0] = cal_code[2];
				`PCS_IDX_SIGN:      rd_mux[8:0] = power_polarity_status;
				`PCS_IDX_CTRL:      rd_mux[1:0] = ctrl;
				`PCS_IDX_TERM_SEL:  rd_mux[8:0] = term_sel;
				`PCS_IDX_QUANT_SEL: rd_mux[8:0] = quant_sel;
				`PCS_IDX_IRQ_STAT:  rd_mux[8:0] = irq_stat;
				`PCS_IDX_IRQ_MASK:  rd_mux[8:0] = irq_mask;
				default:            rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read data register
	// ----------------------------------------------------------------

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hrdata <= 32'h0000_0000;
		end else if (dp_read & ~rd_ready) begin
			hrdata <= rd_mux;
		end
	end

endmodule

`default_nettype wire

// ### pcs_regs_props.sv
// Purpose: Port-level checks for the calibration and power sign block
// Assumes: One clock domain, asynchronous active high reset
// Notes:   Bound to every instance of the register block
`timescale 1ns/100ps
`default_nettype none

module pcs_regs_props #(
	parameter int PW           = 24,
	parameter bit HAS_REACTIVE = 1'b1
) (
	input wire logic            clk,
	input wire logic            reset,
	input wire logic            hsel,
	input wire logic [1:0]      htrans,
	input wire logic            hwrite,
	input wire logic            hready,
	input wire logic            hreadyout,
	input wire logic            hresp,
	input wire logic [31:0]     hrdata,
	input wire logic            power_update,
	input wire logic [3*PW-1:0] total_active,
	input wire logic [3*PW-1:0] total_reactive,
	input wire logic [3*PW-1:0] fund_active,
	input wire logic [3*PW-1:0] fund_reactive,
	input wire logic [26:0]     delay_comp_value,
	input wire logic [2:0]      delay_on_voltage,
	input wire logic [8:0]      power_polarity_status
);
	// ----
	// Checks
	// ----
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite
		|=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
	a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite
		|=> hreadyout) else $error("write stalled");
	a_resp_okay: assert property (hresp == 1'b0) else $error("bad hresp");
	a_upper_zero: assert property (
		hreadyout && $past(!hreadyout) |-> hrdata[31:10] == 22'h0)
		else $error("upper read bits set");
	a_active_sign: assert property (
		power_update && total_active[PW-1] == fund_active[PW-1]
		|=> power_polarity_status[0] == $past(total_active[PW-1]))
		else $error("active sign wrong");
	a_reactive_sign: assert property (
		power_update && HAS_REACTIVE
		&& total_reactive[PW-1] == fund_reactive[PW-1]
		|=> power_polarity_status[4] == $past(total_reactive[PW-1]))
		else $error("reactive sign wrong");
	a_no_reactive: assert property (
		!HAS_REACTIVE |-> power_polarity_status[6:4] == 3'h0)
		else $error("reactive bits set");
	a_sign_hold: assert property (
		!power_update |=> $stable(power_polarity_status))
		else $error("sign word moved");
	a_volt_range: assert property (
		delay_on_voltage[0] |-> delay_comp_value[8:0] <= 9'd63)
		else $error("voltage delay too big");
	a_cur_range: assert property (
		!delay_on_voltage[0] |-> delay_comp_value[8:0] <= 9'd383)
		else $error("current delay too big");
endmodule

bind pcs_regs pcs_regs_props #(.PW(PW), .HAS_REACTIVE(HAS_REACTIVE))
	pcs_regs_props_i (.clk, .reset, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .hresp, .hrdata, .power_update, .total_active,
	.total_reactive, .fund_active, .fund_reactive, .delay_comp_value,
	.delay_on_voltage, .power_polarity_status);

`default_nettype wire

// ### pcs_regs_test.sv
// Purpose: Self-checking bench for the calibration and power sign block
// Assumes: AHB-Lite single word transfers, one slave
// Notes:   A second instance without reactive measurement shares inputs
`timescale 1ns/100ps
`default_nettype none
`include "pcs_consts.svh"

module pcs_regs_test;
	import pcs_pkg::*;
	localparam int PW = 24;
	logic            clk, reset, hsel, hwrite, power_update;
	logic [31:0]     haddr, hwdata, hrdata, r;
	logic [1:0]      htrans;
	logic [2:0]      hsize, dov;
	logic            hreadyout, hresp, irq;
	logic [3*PW-1:0] ta, tr, ap, fa, fr;
	logic [26:0]     dcv;
	pcs_sign_t       pps, pps2;
	int              num_errors, tests_run;
	logic [9:0]      cd [8] = '{0, 383, 384, 511, 512, 575, 576, 1023};
	logic [8:0]      ed [8] = '{0, 383, 256, 383, 0, 63, 320, 383};
	logic            vf [8] = '{0, 0, 0, 0, 1, 1, 0, 0};

	pcs_regs #(.PW(PW), .HAS_REACTIVE(1'b1)) pcs_regs_i (.clk(clk),
		.reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .power_update(power_update), .total_active(ta),
		.total_reactive(tr), .apparent(ap), .fund_active(fa),
		.fund_reactive(fr), .delay_comp_value(dcv),
		.delay_on_voltage(dov), .power_polarity_status(pps), .irq(irq));
	pcs_regs #(.PW(PW), .HAS_REACTIVE(1'b0)) pcs_regs_nr_i (.clk(clk),
		.reset(reset), .hsel(1'b0), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(1'b1),
		.hreadyout(), .hresp(), .hrdata(), .power_update(power_update),
		.total_active(ta), .total_reactive(tr), .apparent(ap),
		.fund_active(fa), .fund_reactive(fr), .delay_comp_value(),
		.delay_on_voltage(), .power_polarity_status(pps2), .irq());

	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic xfer(input logic [15:0] idx, input logic w,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {14'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	task automatic rd(input logic [15:0] idx, input logic [31:0] e);
		xfer(idx, 1'b0, 32'h0);
		chk(r, e);
	endtask

	task automatic pulse_update;
		power_update <= 1'b1;
		@(posedge clk);
		power_update <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task automatic end_of_test;
		$display("errors %0d, checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// ----
	// Stimulus
	// ----
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#200000;
		num_errors++;
		end_of_test();
	end

	initial begin
		{reset, hsel, hwrite, power_update, htrans} = 6'h20;
		{haddr, hwdata, ta, tr, ap, fa, fr} = '0;
		hsize = 3'h2;
		num_errors = 0;
		tests_run = 0;
		repeat (4) @(posedge clk);
		chk(hreadyout, 1'b1);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		rd(`PCS_IDX_PHASE_A, 32'h0);
		rd(`PCS_IDX_SIGN, 32'h0);
		for (int i = 0; i < 8; i++) begin
			xfer(`PCS_IDX_PHASE_A, 1'b1, {22'h0, cd[i]});
			repeat (2) @(posedge clk);
			chk(dcv[8:0], ed[i]);
			chk(dov[0], vf[i]);
		end
		xfer(`PCS_IDX_PHASE_B, 1'b1, 32'h0000fc05);
		rd(`PCS_IDX_PHASE_B, 32'h5);
		chk(dcv[17:9], 9'h5);
		ta <= {24'hffffff, 24'h000001, 24'hfffffb};
		tr <= {24'hfffffd, 24'hffffff, 24'h000001};
		ap <= {3{24'h000010}};
		fa <= {3{24'h000002}};
		fr <= {3{24'h000002}};
		pulse_update();
		chk(pps, 9'h0ed);
		chk(pps2, 9'h00d);
		chk(irq, 1'b0);
		xfer(`PCS_IDX_IRQ_MASK, 1'b1, 32'h8);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		rd(`PCS_IDX_IRQ_STAT, 32'h0ed);
		xfer(`PCS_IDX_IRQ_STAT, 1'b1, 32'h0ed);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		xfer(`PCS_IDX_CTRL, 1'b1, 32'h1);
		xfer(`PCS_IDX_TERM_SEL, 1'b1, 32'h1fa);
		xfer(`PCS_IDX_SIGN, 1'b1, 32'h1ff);
		rd(`PCS_IDX_SIGN, 32'h0ed);
		pulse_update();
		rd(`PCS_IDX_SIGN, 32'h0e0);
		rd(`PCS_IDX_IRQ_STAT, 32'h00d);
		chk(irq, 1'b1);
		xfer(16'h0123, 1'b1, 32'h55);
		rd(16'h0123, 32'h0);
		end_of_test();
	end
endmodule

`default_nettype wire
